// ===== hw/pols_params.svh
// Register offsets, reset values, function codes and timing counts for the loop-selection block.
`ifndef POLS_PARAMS_SVH
`define POLS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------------
`define POLS_ADDR_EXT_ENABLE    16'h0605
`define POLS_ADDR_EXT_SETPOINT  16'h0606
`define POLS_ADDR_EXT_FEEDBACK  16'h0607
`define POLS_RST_EXT_ENABLE     16'h0000
`define POLS_RST_EXT_SETPOINT   16'h0000
`define POLS_RST_EXT_FEEDBACK   16'h0003

// ----------------------------------------------------------------------------
// Digital input function codes
// ----------------------------------------------------------------------------
`define POLS_DI_INTEG_CLEAR     8'h0e
`define POLS_DI_BYPASS_HOLD     8'h0f
`define POLS_DI_BYPASS_PRESET   8'h1e

// ----------------------------------------------------------------------------
// Analog input and output function codes
// ----------------------------------------------------------------------------
`define POLS_AUX_FREQ_CMD       8'h09
`define POLS_AUX_EXT_SETPOINT   8'h12
`define POLS_AUX_EXT_FEEDBACK   8'h13
`define POLS_AO_EXT_LOOP_OUT    8'h0e

// ----------------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------------
`define POLS_LOOP_MODE_MAX      4'h8
`define POLS_EXT_DISABLED       16'h0000
`define POLS_EXT_ON_AO1         16'h0001
`define POLS_EXT_ON_AO2         16'h0002
`define POLS_SRC_KEYPAD         16'h0000
`define POLS_SRC_VOLTAGE        16'h0001
`define POLS_SRC_CURRENT        16'h0002
`define POLS_SRC_AUX            16'h0003
`define POLS_SRC_SERIAL         16'h0004

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define POLS_CLK_HZ             40000000
`define POLS_UPDATE_US          5
`define POLS_UPDATE_CYCLES      ((`POLS_UPDATE_US * (`POLS_CLK_HZ / 1000000)))

`endif

// ===== hw/pols_pkg.sv
// Types shared by the loop-selection block.
package pols_pkg;

    // ------------------------------------------------------------------------
    // Frequency command source
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        POLS_FSRC_LOOP    = 3'b000,
        POLS_FSRC_KEYPAD  = 3'b001,
        POLS_FSRC_AUX     = 3'b010,
        POLS_FSRC_VOLTAGE = 3'b011,
        POLS_FSRC_SERIAL  = 3'b100,
        POLS_FSRC_PULSE   = 3'b101,
        POLS_FSRC_TARGET  = 3'b110,
        POLS_FSRC_PRESET  = 3'b111
    } pols_fsrc_t;

    // ------------------------------------------------------------------------
    // Register read and write port
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pols_reg_req_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic        ack;
        logic        err;
    } pols_reg_rsp_t;

    // ------------------------------------------------------------------------
    // Drive configuration seen by the block
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  loop_mode_select;
        logic [7:0]  input5_function_select;
        logic [7:0]  input6_function_select;
        logic [7:0]  input7_function_select;
        logic [7:0]  input8_function_select;
        logic [1:0]  freq_command_source_select;
        logic [7:0]  aux_input_function_select;
        logic [7:0]  analog_out1_function_select;
        logic [7:0]  analog_out2_function_select;
    } pols_cfg_t;

    // ------------------------------------------------------------------------
    // Selection outcome
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        integ_clear;
        logic        loop_enabled;
        logic        loop_bypassed;
        pols_fsrc_t  freq_src;
        logic [15:0] freq_cmd;
        logic        ext_loop_enabled;
        logic [7:0]  aux_function;
        logic [7:0]  ao1_function;
        logic [7:0]  ao2_function;
        logic        ext_setting_error;
        logic        update_strobe;
    } pols_sel_t;

endpackage

// ===== hw/pols_ext_regs.sv
// External-loop configuration registers on the serial register port.
`include "pols_params.svh"

module pols_ext_regs (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // Register port
    input  wire pols_pkg::pols_reg_req_t req,
    output pols_pkg::pols_reg_rsp_t rsp,
    // Register contents
    output logic [15:0]             ext_loop_enable_select,
    output logic [15:0]             ext_setpoint_source,
    output logic [15:0]             ext_feedback_source
);
    import pols_pkg::*;

    typedef struct packed {
        logic [15:0]   en;
        logic [15:0]   sp;
        logic [15:0]   fb;
        pols_reg_rsp_t rsp;
    } pols_regs_state_t;

    pols_regs_state_t st_r;
    pols_regs_state_t st_nxt;

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    // An unmapped address answers with ack and err, and reads back zero.
    always_comb begin
        st_nxt           = st_r;
        st_nxt.rsp.ack   = req.wr | req.rd;
        st_nxt.rsp.err   = 1'b0;
        st_nxt.rsp.rdata = 16'h0000;
        if (req.addr == `POLS_ADDR_EXT_ENABLE) begin
            if (req.wr) begin
                st_nxt.en = req.wdata;
            end
            st_nxt.rsp.rdata = st_r.en;
        end else if (req.addr == `POLS_ADDR_EXT_SETPOINT) begin
            if (req.wr) begin
                st_nxt.sp = req.wdata;
            end
            st_nxt.rsp.rdata = st_r.sp;
        end else if (req.addr == `POLS_ADDR_EXT_FEEDBACK) begin
            if (req.wr) begin
                st_nxt.fb = req.wdata;
            end
            st_nxt.rsp.rdata = st_r.fb;
        end else begin
            st_nxt.rsp.err = req.wr | req.rd;
        end
        if (!req.rd) begin
            st_nxt.rsp.rdata = 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r.en  <= `POLS_RST_EXT_ENABLE;
            st_r.sp  <= `POLS_RST_EXT_SETPOINT;
            st_r.fb  <= `POLS_RST_EXT_FEEDBACK;
            st_r.rsp <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rsp                    = st_r.rsp;
    assign ext_loop_enable_select = st_r.en;
    assign ext_setpoint_source    = st_r.sp;
    assign ext_feedback_source    = st_r.fb;

endmodule

// ===== hw/pols_input_sampler.sv
// Registered snapshot of the multi-function digital inputs and their function decode.
`include "pols_params.svh"

module pols_input_sampler #(
    parameter int N_INPUTS = 4
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    resetn,
    // Update strobe
    input  wire logic                    sample,
    // Terminals and their functions
    input  wire logic [N_INPUTS-1:0]     din,
    input  wire logic [N_INPUTS*8-1:0]   din_function,
    // Decoded, registered function levels
    output logic                         integ_clear,
    output logic                         bypass_hold,
    output logic                         bypass_preset
);
    import pols_pkg::*;

    typedef struct packed {
        logic clr;
        logic hold;
        logic preset;
    } pols_samp_state_t;

    pols_samp_state_t          st_r;
    pols_samp_state_t          st_nxt;
    logic [N_INPUTS-1:0]       hit_clr;
    logic [N_INPUTS-1:0]       hit_hold;
    logic [N_INPUTS-1:0]       hit_preset;

    // ------------------------------------------------------------------------
    // Per-terminal decode
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < N_INPUTS; i++) begin : g_term
        assign hit_clr[i]    = din[i] && (din_function[i*8 +: 8] == `POLS_DI_INTEG_CLEAR);
        assign hit_hold[i]   = din[i] && (din_function[i*8 +: 8] == `POLS_DI_BYPASS_HOLD);
        assign hit_preset[i] = din[i] && (din_function[i*8 +: 8] == `POLS_DI_BYPASS_PRESET);
    end

    // Inputs are held between updates so the whole selection sees one snapshot.
    always_comb begin
        st_nxt = st_r;
        if (sample) begin
            st_nxt.clr    = |hit_clr;
            st_nxt.hold   = |hit_hold;
            st_nxt.preset = |hit_preset;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign integ_clear   = st_r.clr;
    assign bypass_hold   = st_r.hold;
    assign bypass_preset = st_r.preset;

endmodule

// ===== hw/pols_loop_select.sv
// Loop override, bypass source selection and external-loop configuration decode.
`include "pols_params.svh"

module pols_loop_select #(
    parameter int N_INPUTS      = 4,
    parameter int UPDATE_CYCLES = `POLS_UPDATE_CYCLES
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    resetn,
    // Serial register port
    input  wire pols_pkg::pols_reg_req_t reg_req,
    output pols_pkg::pols_reg_rsp_t      reg_rsp,
    // Drive configuration
    input  wire pols_pkg::pols_cfg_t     cfg,
    // Digital input terminals 5 to 8
    input  wire logic [N_INPUTS-1:0]     din,
    // Frequency command candidates
    input  wire logic [15:0]             loop_freq_cmd,
    input  wire logic [15:0]             loop_target,
    input  wire logic [15:0]             keypad_freq,
    input  wire logic [15:0]             aux_freq,
    input  wire logic [15:0]             voltage_freq,
    input  wire logic [15:0]             serial_freq,
    input  wire logic [15:0]             pulse_freq,
    input  wire logic [15:0]             preset_speed_sixteen,
    // Selection outcome
    output pols_pkg::pols_sel_t          sel
);
    import pols_pkg::*;

    localparam int CW = $clog2(UPDATE_CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] tick;
        logic [15:0]   held_target;
        pols_sel_t     sel;
    } pols_top_state_t;

    pols_top_state_t st_r;
    pols_top_state_t st_nxt;

    logic [15:0] ext_en;
    logic [15:0] ext_sp;
    logic [15:0] ext_fb;
    logic        update;
    logic        di_clr;
    logic        di_hold;
    logic        di_preset;

    // ------------------------------------------------------------------------
    // Configuration registers and input snapshot
    // ------------------------------------------------------------------------
    pols_ext_regs u_regs (
        .clk                    (clk),
        .resetn                 (resetn),
        .req                    (reg_req),
        .rsp                    (reg_rsp),
        .ext_loop_enable_select (ext_en),
        .ext_setpoint_source    (ext_sp),
        .ext_feedback_source    (ext_fb)
    );

    pols_input_sampler #(
        .N_INPUTS (N_INPUTS)
    ) u_samp (
        .clk           (clk),
        .resetn        (resetn),
        .sample        (update),
        .din           (din),
        .din_function  ({cfg.input8_function_select, cfg.input7_function_select,
                         cfg.input6_function_select, cfg.input5_function_select}),
        .integ_clear   (di_clr),
        .bypass_hold   (di_hold),
        .bypass_preset (di_preset)
    );

    assign update = (st_r.tick == CW'(UPDATE_CYCLES - 1));

    // ------------------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------------------
    always_comb begin
        logic       loop_on;
        logic       ext_on;
        pols_fsrc_t fsrc;
        logic [15:0] fcmd;
        loop_on = 1'b0;
        ext_on  = 1'b0;
        fsrc    = POLS_FSRC_LOOP;
        fcmd    = 16'h0000;
        st_nxt  = st_r;
        st_nxt.sel.update_strobe = update;
        st_nxt.tick = update ? '0 : CW'(st_r.tick + 1'b1);

        loop_on = (cfg.loop_mode_select != 4'h0) && (cfg.loop_mode_select <= `POLS_LOOP_MODE_MAX);

        if (update) begin
            st_nxt.sel.integ_clear  = di_clr;
            st_nxt.sel.loop_enabled = loop_on;
            if (loop_on && di_preset) begin
                fsrc = POLS_FSRC_PRESET;
                fcmd = preset_speed_sixteen;
            end else if (loop_on && di_hold) begin
                // A zero keypad value with the loop in hold bypass falls back to the last loop target.
                case (cfg.freq_command_source_select)
                    2'h0: begin
                        if (keypad_freq == 16'h0000) begin
                            fsrc = POLS_FSRC_TARGET;
                            fcmd = st_r.held_target;
                        end else begin
                            fsrc = POLS_FSRC_KEYPAD;
                            fcmd = keypad_freq;
                        end
                    end
                    2'h1: begin
                        if (cfg.aux_input_function_select == `POLS_AUX_FREQ_CMD) begin
                            fsrc = POLS_FSRC_AUX;
                            fcmd = aux_freq;
                        end else begin
                            fsrc = POLS_FSRC_VOLTAGE;
                            fcmd = voltage_freq;
                        end
                    end
                    2'h2: begin
                        fsrc = POLS_FSRC_SERIAL;
                        fcmd = serial_freq;
                    end
                    default: begin
                        fsrc = POLS_FSRC_PULSE;
                        fcmd = pulse_freq;
                    end
                endcase
            end else if (loop_on) begin
                fsrc = POLS_FSRC_LOOP;
                fcmd = loop_freq_cmd;
                st_nxt.held_target = loop_target;
            end else begin
                fsrc = POLS_FSRC_KEYPAD;
                fcmd = keypad_freq;
            end
            st_nxt.sel.loop_bypassed = loop_on && (di_hold || di_preset);
            st_nxt.sel.freq_src      = fsrc;
            st_nxt.sel.freq_cmd      = fcmd;
        end

        // External loop configuration follows the registers every cycle.
        ext_on = (ext_en == `POLS_EXT_ON_AO1) || (ext_en == `POLS_EXT_ON_AO2);
        st_nxt.sel.ext_loop_enabled = ext_on;

        st_nxt.sel.aux_function = cfg.aux_input_function_select;
        if (ext_fb == `POLS_SRC_AUX) begin
            st_nxt.sel.aux_function = `POLS_AUX_EXT_FEEDBACK;
        end
        if (ext_sp == `POLS_SRC_AUX) begin
            st_nxt.sel.aux_function = `POLS_AUX_EXT_SETPOINT;
        end

        st_nxt.sel.ao1_function = cfg.analog_out1_function_select;
        st_nxt.sel.ao2_function = cfg.analog_out2_function_select;
        if (ext_en == `POLS_EXT_ON_AO1) begin
            st_nxt.sel.ao1_function = `POLS_AO_EXT_LOOP_OUT;
        end else if (ext_en == `POLS_EXT_ON_AO2) begin
            st_nxt.sel.ao2_function = `POLS_AO_EXT_LOOP_OUT;
        end

        // With the external loop on, both sources naming the same terminal cannot be told apart, so flag it.
        st_nxt.sel.ext_setting_error = ext_on && (ext_sp == ext_fb) &&
                                       (ext_sp >= `POLS_SRC_VOLTAGE) && (ext_sp <= `POLS_SRC_AUX);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sel = st_r.sel;

endmodule

// ===== testbench/pols_loop_select_asserts.sv
// Concurrent checks on the ports of the loop-selection block.
`include "pols_params.svh"

module pols_loop_select_asserts (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    resetn,
    // Register port
    input wire pols_pkg::pols_reg_req_t reg_req,
    input wire pols_pkg::pols_reg_rsp_t reg_rsp,
    // Configuration, preset and outcome
    input wire pols_pkg::pols_cfg_t     cfg,
    input wire logic [15:0]             preset_speed_sixteen,
    input wire pols_pkg::pols_sel_t     sel
);
    timeunit 1ns;
    timeprecision 1ps;
    import pols_pkg::*;

    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    sequence ext_wr_s(logic [15:0] v);
        reg_req.wr && reg_req.addr == `POLS_ADDR_EXT_ENABLE && reg_req.wdata == v;
    endsequence

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    selection_stands_a: assert property (
        ($changed(sel.freq_cmd) || $changed(sel.freq_src)) |-> sel.update_strobe)
        else $error("Selection changed without an update strobe.");
    loop_mode_range_a: assert property (
        sel.update_strobe |-> sel.loop_enabled == ($past(cfg.loop_mode_select) inside {[4'h1:4'h8]}))
        else $error("Loop enable does not follow the loop mode.");
    bypass_needs_loop_a: assert property (sel.loop_bypassed |-> sel.loop_enabled)
        else $error("Bypass seen while the loop is off.");
    bypass_opens_loop_a: assert property (sel.loop_bypassed |-> sel.freq_src != POLS_FSRC_LOOP)
        else $error("Bypass still selects the loop output.");
    preset_command_a: assert property (
        sel.update_strobe && sel.freq_src == POLS_FSRC_PRESET |-> sel.freq_cmd == $past(preset_speed_sixteen))
        else $error("Preset source does not carry preset sixteen.");
    ao1_forced_a: assert property (
        ext_wr_s(16'h0001) |-> ##2 sel.ao1_function == `POLS_AO_EXT_LOOP_OUT && sel.ext_loop_enabled)
        else $error("First analog output not given the loop function.");
    ao2_forced_a: assert property (
        ext_wr_s(16'h0002) |-> ##2 sel.ao2_function == `POLS_AO_EXT_LOOP_OUT && sel.ext_loop_enabled)
        else $error("Second analog output not given the loop function.");
    reg_ack_once_a: assert property (reg_rsp.ack == $past(reg_req.wr || reg_req.rd))
        else $error("Register acknowledge not exactly one cycle after access.");
endmodule

bind pols_loop_select pols_loop_select_asserts chk (
    .clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .cfg(cfg), .preset_speed_sixteen(preset_speed_sixteen), .sel(sel));

// ===== testbench/pols_host_model.sv
// Serial register master that drives the block's register port.
module pols_host_model (
    // Clock
    input  wire logic                    clk,
    // Register port
    output pols_pkg::pols_reg_req_t      req,
    input  wire pols_pkg::pols_reg_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    import pols_pkg::*;

    initial req = '0;

    // The strobe stands one cycle only; holding it would be a second access.
    // Released address and data show the inverse so stale values never match.
    task automatic access(input logic wr, input logic [15:0] a, d,
                          output logic [15:0] q, output logic e, output logic ok);
        int i;
        @(negedge clk);
        req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
        ok = 1'b0;
        // The answer stands only in the cycle right after the strobe, so look from there on.
        for (i = 0; i < 4 && !ok; i++) begin
            @(negedge clk);
            req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
            ok = rsp.ack;
        end
        q = rsp.rdata;
        e = rsp.err;
    endtask
endmodule

// ===== testbench/test_pols_loop_select.sv
// Self-checking bench for the loop-selection block.
`include "pols_params.svh"

module test_pols_loop_select;
    timeunit 1ns;
    timeprecision 1ps;
    import pols_pkg::*;

    typedef struct packed {
        logic [3:0]  mode;
        logic [7:0]  f5;
        logic [7:0]  f8;
        logic [3:0]  din;
        logic [1:0]  fs;
        logic [7:0]  auxf;
        logic [2:0]  src;
        logic [15:0] cmd;
        logic        en;
        logic        byp;
        logic        iclr;
    } pols_row_t;

    logic          clk;
    logic          resetn;
    pols_reg_req_t req;
    pols_reg_rsp_t rsp;
    pols_cfg_t     cfg;
    logic [3:0]    din;
    pols_sel_t     sel;
    logic [15:0]   fq [8];
    logic [15:0]   q;
    logic          e;
    logic          ok;
    int            fails;
    int            checks;
    pols_row_t     rows [12];

    pols_loop_select #(.N_INPUTS(4), .UPDATE_CYCLES(4)) DUT (
        .clk(clk), .resetn(resetn), .reg_req(req), .reg_rsp(rsp), .cfg(cfg), .din(din),
        .loop_freq_cmd(fq[0]), .loop_target(fq[1]), .keypad_freq(fq[2]), .aux_freq(fq[3]),
        .voltage_freq(fq[4]), .serial_freq(fq[5]), .pulse_freq(fq[6]),
        .preset_speed_sixteen(fq[7]), .sel(sel));

    pols_host_model host (.clk(clk), .req(req), .rsp(rsp));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // A terminal change reaches the outcome within two updates; three is safe.
    task automatic settle();
        int n;
        int i;
        n = 0;
        for (i = 0; i < 60 && n < 3; i++) begin
            @(negedge clk);
            if (sel.update_strobe === 1'b1)
                n++;
        end
        if (n < 3) begin
            fails++;
            $display("MISMATCH at %0t: no update strobe", $time);
            conclude();
        end
    endtask

    task automatic reg_io(input logic w, input logic [15:0] a, d);
        host.access(w, a, d, q, e, ok);
        check({15'h0, ok}, 16'h0001);
        if (ok !== 1'b1)
            conclude();
        @(negedge clk);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int i;
        resetn = 1'b0;
        cfg = '0;
        din = '0;
        fails = 0;
        checks = 0;
        for (i = 0; i < 8; i++)
            fq[i] = 16'h1111 * 16'(i + 1);
        rows = '{
            '{4'h1, 8'h0f, 8'h00, 4'h0, 2'h0, 8'h00, 3'h0, 16'h1111, 1'b1, 1'b0, 1'b0},
            '{4'h1, 8'h0f, 8'h00, 4'h1, 2'h0, 8'h00, 3'h1, 16'h3333, 1'b1, 1'b1, 1'b0},
            '{4'h1, 8'h0f, 8'h00, 4'h1, 2'h1, 8'h09, 3'h2, 16'h4444, 1'b1, 1'b1, 1'b0},
            '{4'h1, 8'h0f, 8'h00, 4'h1, 2'h1, 8'h00, 3'h3, 16'h5555, 1'b1, 1'b1, 1'b0},
            '{4'h1, 8'h0f, 8'h00, 4'h1, 2'h2, 8'h00, 3'h4, 16'h6666, 1'b1, 1'b1, 1'b0},
            '{4'h1, 8'h0f, 8'h00, 4'h1, 2'h3, 8'h00, 3'h5, 16'h7777, 1'b1, 1'b1, 1'b0},
            '{4'h1, 8'h1e, 8'h00, 4'h1, 2'h0, 8'h00, 3'h7, 16'h8888, 1'b1, 1'b1, 1'b0},
            '{4'h1, 8'h0f, 8'h1e, 4'h9, 2'h0, 8'h00, 3'h7, 16'h8888, 1'b1, 1'b1, 1'b0},
            '{4'h8, 8'h1e, 8'h00, 4'h1, 2'h0, 8'h00, 3'h7, 16'h8888, 1'b1, 1'b1, 1'b0},
            '{4'h1, 8'h0e, 8'h00, 4'h1, 2'h0, 8'h00, 3'h0, 16'h1111, 1'b1, 1'b0, 1'b1},
            '{4'h0, 8'h1e, 8'h00, 4'h1, 2'h0, 8'h00, 3'h1, 16'h3333, 1'b0, 1'b0, 1'b0},
            '{4'h9, 8'h1e, 8'h00, 4'h1, 2'h0, 8'h00, 3'h1, 16'h3333, 1'b0, 1'b0, 1'b0}};
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check({8'h0, sel.aux_function}, {8'h0, `POLS_AUX_EXT_FEEDBACK});
        reg_io(1'b0, `POLS_ADDR_EXT_ENABLE, 16'h0000);
        check(q, `POLS_RST_EXT_ENABLE);
        reg_io(1'b0, `POLS_ADDR_EXT_SETPOINT, 16'h0000);
        check(q, `POLS_RST_EXT_SETPOINT);
        reg_io(1'b0, `POLS_ADDR_EXT_FEEDBACK, 16'h0000);
        check(q, `POLS_RST_EXT_FEEDBACK);
        // Move feedback off the AUX terminal so the AUX function is the user's.
        reg_io(1'b1, `POLS_ADDR_EXT_FEEDBACK, `POLS_SRC_VOLTAGE);
        for (i = 0; i < 12; i++) begin
            cfg.loop_mode_select = rows[i].mode;
            cfg.input5_function_select = rows[i].f5;
            cfg.input8_function_select = rows[i].f8;
            cfg.freq_command_source_select = rows[i].fs;
            cfg.aux_input_function_select = rows[i].auxf;
            din = rows[i].din;
            settle();
            check({15'h0, sel.loop_enabled}, {15'h0, rows[i].en});
            check({15'h0, sel.loop_bypassed}, {15'h0, rows[i].byp});
            check({15'h0, sel.integ_clear}, {15'h0, rows[i].iclr});
            check({13'h0, sel.freq_src}, {13'h0, rows[i].src});
            check(sel.freq_cmd, rows[i].cmd);
        end
        reg_io(1'b0, 16'h0608, 16'h0000);
        check({15'h0, e}, 16'h0001);
        check(q, 16'h0000);
        reg_io(1'b1, `POLS_ADDR_EXT_ENABLE, `POLS_EXT_ON_AO1);
        check({8'h0, sel.ao1_function}, {8'h0, `POLS_AO_EXT_LOOP_OUT});
        check({15'h0, sel.ext_loop_enabled}, 16'h0001);
        reg_io(1'b1, `POLS_ADDR_EXT_ENABLE, `POLS_EXT_ON_AO2);
        check({8'h0, sel.ao2_function}, {8'h0, `POLS_AO_EXT_LOOP_OUT});
        reg_io(1'b1, `POLS_ADDR_EXT_SETPOINT, `POLS_SRC_AUX);
        check({8'h0, sel.aux_function}, {8'h0, `POLS_AUX_EXT_SETPOINT});
        reg_io(1'b1, `POLS_ADDR_EXT_SETPOINT, `POLS_SRC_CURRENT);
        reg_io(1'b1, `POLS_ADDR_EXT_FEEDBACK, `POLS_SRC_CURRENT);
        check({15'h0, sel.ext_setting_error}, 16'h0001);
        reg_io(1'b1, `POLS_ADDR_EXT_FEEDBACK, `POLS_SRC_VOLTAGE);
        check({15'h0, sel.ext_setting_error}, 16'h0000);
        reg_io(1'b0, `POLS_ADDR_EXT_SETPOINT, 16'h0000);
        check(q, `POLS_SRC_CURRENT);
        reg_io(1'b1, `POLS_ADDR_EXT_ENABLE, `POLS_EXT_DISABLED);
        check({15'h0, sel.ext_loop_enabled}, 16'h0000);
        // A zero keypad value in hold bypass falls back to the target latched in closed loop.
        cfg.loop_mode_select = 4'h1;
        cfg.input5_function_select = `POLS_DI_BYPASS_HOLD;
        din = 4'h0;
        fq[1] = 16'h2468;
        fq[2] = 16'h0000;
        settle();
        din = 4'h1;
        settle();
        fq[1] = 16'h0bad;
        settle();
        check({13'h0, sel.freq_src}, {13'h0, POLS_FSRC_TARGET});
        check(sel.freq_cmd, 16'h2468);
        // A reset in mid-run clears the outcome and restores the register defaults.
        resetn = 1'b0;
        @(negedge clk);
        check(sel.freq_cmd, 16'h0000);
        resetn = 1'b1;
        @(negedge clk);
        check({8'h0, sel.aux_function}, {8'h0, `POLS_AUX_EXT_FEEDBACK});
        reg_io(1'b0, `POLS_ADDR_EXT_SETPOINT, 16'h0000);
        check(q, `POLS_RST_EXT_SETPOINT);
        conclude();
    end
endmodule
